// [rtl/dtm_trace_gen.v]
// Contract
// - pending sync turns write into write sync
// - pending sync turns read into read sync
// - sync pending after reset release
// - sync pending when trace enable rises running
// - sync pending on power-down exit
// - event-in with sync action sets pending
// - overrun error message precedes next sync
// - periodic counter forces sync, 256/255
// - first access after debug exit syncs
// - full address with leading zeros dropped
// - data sized to access, size code
// - unique address is xor with previous
// - plain read makes compressed read message
// - sync codes 13 and 14
// - compressed read code 6
// - rmw access makes rmw message
// - bit index five bits
// - op code clear 01 set 10 toggle 11
// - compressed rmw code 58
// - plain write makes compressed write, code 5
// - rmw sync code 59 full address
`timescale 1ns/1ps
`include "dtm_defines.vh"
module dtm_trace_gen (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        trace_en,
  input  wire        cpu_running,
  input  wire        pdown_exit,
  input  wire        debug_exit,
  input  wire        evti_pin,
  input  wire        evti_sync_sel,
  input  wire        acc_valid,
  input  wire [1:0]  acc_kind,
  input  wire [31:0] acc_addr,
  input  wire [31:0] acc_data,
  input  wire [1:0]  acc_size,
  input  wire [4:0]  acc_bit,
  input  wire [1:0]  acc_op,
  output wire        acc_ready,
  output wire        acc_dropped,
  output reg         msg_valid,
  input  wire        msg_ready,
  output reg  [5:0]  msg_tcode,
  output reg  [1:0]  msg_field1,
  output reg  [31:0] msg_addr,
  output reg  [5:0]  msg_addr_len,
  output reg  [31:0] msg_value,
  output reg  [5:0]  msg_value_len,
  output reg  [4:0]  msg_bit
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  localparam NSR     = 5;
  localparam SR_RST  = 0;
  localparam SR_EN   = 1;
  localparam SR_PD   = 2;
  localparam SR_EVT  = 3;
  localparam SR_DBG  = 4;
  localparam [NSR-1:0] SR_INIT = `DTM_SYNC_INIT;

  reg            st_r;
  reg            ovr_r;
  reg            ovr_sent_r;
  reg  [8:0]     cnt_r;
  reg  [31:0]    ref_r;
  reg            en_d_r;
  reg            evti_m_r;
  reg            evti_s_r;
  reg            evti_d_r;
  reg  [NSR-1:0] sync_rsn_r;
  reg  [81:0]    fifo_in_nxt;
  reg  [31:0]    val_mask_c;
  reg  [5:0]     tc_c;
  reg  [5:0]     out_vlen_c;

  wire           fifo_in_ready;
  wire           fifo_out_valid;
  wire [81:0]    fifo_out;
  wire           push_ok;
  wire           evti_rise;
  wire           en_rise;
  wire           period_hit;
  wire           is_sync;
  wire           need_err;
  wire           is_read;
  wire           is_rmw;
  wire           sync_clr;
  wire           sync_any;
  wire           out_load;
  wire           out_is_rmw;
  wire           out_is_err;
  wire [NSR-1:0] sync_set;
  wire [31:0]    diff;
  wire [31:0]    sel_addr;
  wire [31:0]    sel_val;
  wire [5:0]     addr_len_c;
  wire [5:0]     len_at [0:32];
  wire [5:0]     out_tc;
  genvar         g;

  assign is_read   = (acc_kind == `DTM_KIND_READ);
  assign is_rmw    = (acc_kind == `DTM_KIND_RMW);
  assign evti_rise = evti_s_r & ~evti_d_r;
  assign en_rise   = trace_en & ~en_d_r & cpu_running;
  // write limit is the larger; reads share the counter but stop one earlier
  assign period_hit = is_read ? (cnt_r >= `DTM_RD_PERIOD)
                              : (cnt_r >= `DTM_WR_PERIOD);

  // a debug or power-down exit in the access's own cycle already counts
  assign is_sync   = sync_any | ovr_r | period_hit | debug_exit | pdown_exit;
  assign need_err  = ovr_r & ~ovr_sent_r;
  // xor keeps only the bits that changed since the last message
  assign diff      = acc_addr ^ ref_r;
  assign sel_addr  = is_sync ? acc_addr : diff;
  assign sel_val   = acc_data & val_mask_c;

  // only traced while enabled; the tool arms the enable beforehand
  assign push_ok   = acc_valid & trace_en & fifo_in_ready & ~need_err;
  // accesses are never stalled: a full queue discards and flags overrun
  assign acc_ready   = 1'b1;
  assign acc_dropped = acc_valid & trace_en & ~fifo_in_ready;

  assign sync_set[SR_RST] = 1'b0;
  assign sync_set[SR_EN]  = en_rise;
  assign sync_set[SR_PD]  = pdown_exit;
  assign sync_set[SR_EVT] = evti_rise & evti_sync_sel;
  assign sync_set[SR_DBG] = debug_exit;
  assign sync_clr = push_ok & is_sync;
  assign sync_any = |sync_rsn_r;

  // one flag per reason, so each cause of a sync can be watched on its own
  generate
    for (g = 0; g < NSR; g = g + 1) begin : g_sync
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync_rsn_r[g] <= SR_INIT[g];
        end else if (sync_set[g]) begin
          sync_rsn_r[g] <= 1'b1;
        end else if (sync_clr) begin
          sync_rsn_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // highest set bit plus one; leading zeros are not sent
  assign len_at[0] = 6'h00;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_len
      localparam [5:0] BIT_LEN = g + 1;
      assign len_at[g+1] = sel_addr[g] ? BIT_LEN : len_at[g];
    end
  endgenerate
  assign addr_len_c = len_at[32];

  always @* begin
    case (acc_size)
      `DTM_SZ_8:  val_mask_c = 32'h000000FF;
      `DTM_SZ_16: val_mask_c = 32'h0000FFFF;
      default:    val_mask_c = 32'hFFFFFFFF;
    endcase
  end

  always @* begin
    case (acc_kind)
      `DTM_KIND_WRITE: begin
        tc_c = is_sync ? `DTM_TC_WRITE_SYNC : `DTM_TC_WRITE;
      end
      `DTM_KIND_RMW: begin
        tc_c = is_sync ? `DTM_TC_RMW_SYNC : `DTM_TC_RMW;
      end
      default: begin
        tc_c = is_sync ? `DTM_TC_READ_SYNC : `DTM_TC_READ;
      end
    endcase
  end

  // code first, then the fields from the last table row up
  always @* begin
    fifo_in_nxt = 82'h0;
    if (need_err) begin
      fifo_in_nxt = {`DTM_TC_ERROR, 2'h0, 32'h0, 6'h00, 27'h0, `DTM_ECODE_OVR, 4'h0};
    end else if (is_rmw) begin
      // the bit argument rides in the low end of the value slot
      fifo_in_nxt = {tc_c, acc_op, sel_addr, addr_len_c, 27'h0, acc_bit, 4'h0};
    end else begin
      fifo_in_nxt = {tc_c, acc_size, sel_addr, addr_len_c, sel_val, 4'h0};
    end
  end

  // the queue absorbs bursts; past its depth accesses are dropped, not stalled
  dtm_fifo #(
    .W  (`DTM_FIFO_W),
    .D  (`DTM_FIFO_D),
    .AW (`DTM_FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  ((acc_valid & trace_en) | need_err),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_nxt),
    .out_valid (fifo_out_valid),
    .out_ready (st_r == ST_IDLE),
    .out_data  (fifo_out)
  );

  // two flops first, the pin is not of this clock
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evti_m_r <= 1'b0;
      evti_s_r <= 1'b0;
      evti_d_r <= 1'b0;
    end else begin
      evti_m_r <= evti_pin;
      evti_s_r <= evti_m_r;
      evti_d_r <= evti_s_r;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= trace_en;
    end
  end

  // one counter serves both kinds; reads trip one count earlier
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 9'h000;
    end else if (push_ok) begin
      if (is_sync) begin
        cnt_r <= 9'h000;
      end else begin
        cnt_r <= cnt_r + 9'h001;
      end
    end
  end

  // error messages do not move the reference
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_r <= 32'h0;
    end else if (push_ok) begin
      ref_r <= acc_addr;
    end
  end

  // a drop in the cycle of the clear wins, so no overrun goes unreported
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovr_r      <= 1'b0;
      ovr_sent_r <= 1'b0;
    end else if (acc_dropped) begin
      ovr_r      <= 1'b1;
      ovr_sent_r <= 1'b0;
    end else if (push_ok & is_sync) begin
      ovr_r      <= 1'b0;
      ovr_sent_r <= 1'b0;
    end else if (need_err & fifo_in_ready) begin
      ovr_sent_r <= 1'b1;
    end
  end

  // output stage: one message at a time off the queue
  assign out_load   = (st_r == ST_IDLE) & fifo_out_valid;
  assign out_tc     = fifo_out[81:76];
  assign out_is_rmw = (out_tc == `DTM_TC_RMW) | (out_tc == `DTM_TC_RMW_SYNC);
  assign out_is_err = (out_tc == `DTM_TC_ERROR);

  // value width follows the size code; an rmw carries none, an error carries a 5-bit code
  always @* begin
    if (out_is_err) begin
      out_vlen_c = 6'h05;
    end else if (out_is_rmw) begin
      out_vlen_c = 6'h00;
    end else begin
      case (fifo_out[75:74])
        `DTM_SZ_8:  out_vlen_c = 6'h08;
        `DTM_SZ_16: out_vlen_c = 6'h10;
        default:    out_vlen_c = 6'h20;
      endcase
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r      <= ST_IDLE;
      msg_valid <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (fifo_out_valid) begin
            st_r      <= ST_SEND;
            msg_valid <= 1'b1;
          end
        end
        ST_SEND: begin
          // valid drops for a cycle after every handshake
          if (msg_ready) begin
            st_r      <= ST_IDLE;
            msg_valid <= 1'b0;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // fields load only when a message is taken, so they stand while stalled
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msg_tcode     <= 6'h00;
      msg_field1    <= 2'h0;
      msg_addr      <= 32'h0;
      msg_addr_len  <= 6'h00;
      msg_value     <= 32'h0;
      msg_value_len <= 6'h00;
      msg_bit       <= 5'h00;
    end else if (out_load) begin
      msg_tcode     <= out_tc;
      msg_field1    <= fifo_out[75:74];
      msg_addr      <= fifo_out[73:42];
      msg_addr_len  <= fifo_out[41:36];
      msg_value     <= out_is_rmw ? 32'h0 : fifo_out[35:4];
      msg_value_len <= out_vlen_c;
      msg_bit       <= out_is_rmw ? fifo_out[8:4] : 5'h00;
    end
  end
endmodule

// [rtl/dtm_defines.vh]
`ifndef DTM_DEFINES_VH
`define DTM_DEFINES_VH
`define DTM_TC_WRITE       6'h05
`define DTM_TC_READ        6'h06
`define DTM_TC_ERROR       6'h08
`define DTM_TC_WRITE_SYNC  6'h0D
`define DTM_TC_READ_SYNC   6'h0E
`define DTM_TC_RMW         6'h3A
`define DTM_TC_RMW_SYNC    6'h3B
`define DTM_ECODE_OVR      5'h02
`define DTM_SYNC_INIT      5'h01
`define DTM_SZ_8           2'h0
`define DTM_SZ_16          2'h1
`define DTM_SZ_32          2'h2
`define DTM_OP_CLEAR       2'h1
`define DTM_OP_SET         2'h2
`define DTM_OP_TOGGLE      2'h3
`define DTM_WR_PERIOD      9'h100
`define DTM_RD_PERIOD      9'h0FF
`define DTM_KIND_READ      2'h0
`define DTM_KIND_WRITE     2'h1
`define DTM_KIND_RMW       2'h2
`define DTM_FIFO_W         82
`define DTM_FIFO_D         16
`define DTM_FIFO_AW        4
`endif

// [rtl/dtm_fifo.v]
`timescale 1ns/1ps
module dtm_fifo #(
  parameter W  = 82,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         core_clk,
  input  wire         rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;
  localparam [AW:0] FULL_CNT = D;
  assign in_ready  = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rp_r];
  always @(posedge core_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// [bench/dtm_trace_checker.sv]
`timescale 1ns/1ps
module dtm_trace_checker (
  input logic       core_clk,
  input logic       rst,
  input logic       msg_valid,
  input logic       msg_ready,
  input logic [5:0] msg_tcode,
  input logic [1:0] msg_field1,
  input logic [5:0] msg_value_len
);
  logic seen_r;
  logic err_r;
  wire  hs = msg_valid && msg_ready;
  wire  sz = msg_tcode inside {6'h05, 6'h06, 6'h0D, 6'h0E};
  wire  sy = msg_tcode inside {6'h0D, 6'h0E, 6'h3B};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // flags move only on a handshake, so a stalled message is judged once
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seen_r <= 1'h0;
      err_r  <= 1'h0;
    end else if (hs) begin
      seen_r <= 1'h1;
      err_r  <= msg_tcode == 6'h08;
    end
  end
  AST_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_tcode)
    && $stable(msg_field1)) else $error("message changed while stalled");
  AST_GAP: assert property (hs |=> !msg_valid) else $error("no idle after handshake");
  AST_CODE: assert property (msg_valid |-> msg_tcode inside {6'h05, 6'h06, 6'h08, 6'h0D,
    6'h0E, 6'h3A, 6'h3B}) else $error("unknown transfer code");
  AST_SIZE: assert property (msg_valid && sz |-> msg_field1 != 2'h3
    && msg_value_len == (6'h08 << msg_field1)) else $error("size code and width differ");
  AST_OP: assert property (msg_valid && msg_tcode inside {6'h3A, 6'h3B} |-> msg_field1 != 2'h0)
    else $error("reserved bit operation");
  AST_FIRST: assert property (msg_valid && !seen_r |-> sy) else $error("first not sync");
  AST_ERR: assert property (msg_valid && err_r |-> sy) else $error("no sync after error");
  AST_ERRF: assert property (msg_valid && msg_tcode == 6'h08 |-> msg_field1 == 2'h0)
    else $error("error message field set");
endmodule
bind dtm_trace_gen dtm_trace_checker chk (.*);

// [bench/dtm_tool_model.sv]
`timescale 1ns/1ps
module dtm_tool_model (
  input  logic        core_clk,
  input  logic        rst,
  input  logic        stall,
  input  logic        msg_valid,
  output logic        msg_ready,
  input  logic [5:0]  msg_tcode,
  input  logic [1:0]  msg_field1,
  input  logic [31:0] msg_addr,
  input  logic [31:0] msg_value,
  input  logic [4:0]  msg_bit
);
  logic [5:0]  q[$];
  logic [1:0]  f_r;
  logic [31:0] a_r;
  logic [31:0] v_r;
  logic [4:0]  b_r;
  // ready lags stall by an edge, as a tool whose buffer fills up
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msg_ready <= 1'h0;
    end else begin
      msg_ready <= !stall;
      if (msg_valid && msg_ready) begin
        q.push_back(msg_tcode);
        f_r <= msg_field1;
        a_r <= msg_addr;
        v_r <= msg_value;
        b_r <= msg_bit;
      end
    end
  end
endmodule

// [bench/dtm_trace_gen_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h, expected %h", $time, g, e); end end
module dtm_trace_gen_tb;
  typedef struct {logic [1:0] k; logic [31:0] a; logic [1:0] f; logic [2:0] ev;
    logic [5:0] tc; logic [31:0] ea;} dtm_row_t;
  logic        core_clk = 0, rst = 1, trace_en = 1, pdown_exit = 0, debug_exit = 0;
  logic        evti_pin = 0, acc_valid = 0, stall = 0, drop_seen = 0;
  logic        acc_ready, acc_dropped, msg_valid, msg_ready;
  logic [1:0]  acc_kind = 0, acc_size = 0, acc_op = 1, msg_field1;
  logic [31:0] acc_addr = 0, msg_addr, msg_value, m;
  logic [5:0]  msg_tcode, msg_addr_len, msg_value_len;
  logic [4:0]  acc_bit = 5'h15, msg_bit;
  int          failures = 0, comparisons = 0, n = 0;
  dtm_row_t rows [9] = '{'{2'h1, 32'h1000, 2'h2, 3'h0, 6'h0D, 32'h1000},
    '{2'h1, 32'h1004, 2'h0, 3'h0, 6'h05, 32'h4}, '{2'h0, 32'h1010, 2'h1, 3'h0, 6'h06, 32'h14},
    '{2'h2, 32'h1010, 2'h1, 3'h0, 6'h3A, 32'h0}, '{2'h2, 32'h1011, 2'h2, 3'h0, 6'h3A, 32'h1},
    '{2'h0, 32'h2000, 2'h2, 3'h1, 6'h0E, 32'h2000}, '{2'h2, 32'h2100, 2'h3, 3'h2, 6'h3B, 32'h2100},
    '{2'h1, 32'h80000000, 2'h1, 3'h3, 6'h0D, 32'h80000000}, '{2'h0, 32'h7, 2'h0, 3'h4, 6'h0E, 32'h7}};
  dtm_trace_gen dut (.core_clk, .rst, .trace_en, .cpu_running(1'h1), .pdown_exit, .debug_exit,
    .evti_pin, .evti_sync_sel(1'h1), .acc_valid, .acc_kind, .acc_addr, .acc_data(32'hA5C396F0),
    .acc_size, .acc_bit, .acc_op, .acc_ready, .acc_dropped, .msg_valid, .msg_ready, .msg_tcode,
    .msg_field1, .msg_addr, .msg_addr_len, .msg_value, .msg_value_len, .msg_bit);
  dtm_tool_model tool (.core_clk, .rst, .stall, .msg_valid, .msg_ready, .msg_tcode, .msg_field1,
    .msg_addr, .msg_value, .msg_bit);
  initial forever #10 core_clk = ~core_clk;
  task give_verdict;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wait_n(input int c);
    int t;
    t = 0;
    while (tool.q.size() < c && t < 4000) begin
      @(negedge core_clk);
      t++;
    end
    if (t == 4000) begin
      failures++;
      give_verdict;
    end
  endtask
  // gap 0 keeps valid high, one access per edge
  task burst(input logic [1:0] k, input logic [31:0] a, input int c, input int g);
    for (int i = 0; i < c; i++) begin
      acc_kind = k;
      acc_addr = a + 32'(4 * i);
      acc_valid = 1'h1;
      #1 drop_seen |= acc_dropped;
      @(negedge core_clk);
      if (g > 0) acc_valid = 1'h0;
      repeat (g) @(negedge core_clk);
    end
    acc_valid = 1'h0;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 0;
    `CHK(msg_valid, 1'h0)
    `CHK(acc_ready, 1'h1)
    foreach (rows[i]) begin
      case (rows[i].ev)
        3'h1: debug_exit = 1;
        3'h2: pdown_exit = 1;
        3'h3: evti_pin = 1;
        3'h4: trace_en = 0;
        default: ;
      endcase
      @(negedge core_clk);
      {debug_exit, pdown_exit} = 2'h0;
      repeat (3) @(negedge core_clk);
      {evti_pin, trace_en} = 2'h1;
      repeat (3) @(negedge core_clk);
      acc_size = rows[i].k == 2'h2 ? 2'h2 : rows[i].f;
      acc_op = rows[i].f;
      burst(rows[i].k, rows[i].a, 1, 1);
      n++;
      wait_n(n);
      `CHK(tool.q[n-1], rows[i].tc)
      `CHK(tool.a_r, rows[i].ea)
      `CHK(msg_addr_len, 6'($clog2(rows[i].ea + 33'h1)))
      `CHK(msg_value_len, rows[i].k == 2'h2 ? 6'h00 : 6'h08 << rows[i].f)
      `CHK(tool.f_r, rows[i].f)
      m = ~(32'hFFFFFFFF << (6'h08 << rows[i].f));
      if (rows[i].k == 2'h2) `CHK(tool.b_r, 5'h15)
      else `CHK(tool.v_r & m, 32'hA5C396F0 & m)
    end
    debug_exit = 1;
    @(negedge core_clk);
    debug_exit = 0;
    burst(2'h1, 32'h4000, 258, 3);
    burst(2'h0, 32'h5000, 256, 3);
    n += 514;
    wait_n(n);
    `CHK(tool.q[n-258], 6'h05)
    `CHK(tool.q[n-257], 6'h0D)
    `CHK(tool.q[n-2], 6'h06)
    `CHK(tool.q[n-1], 6'h0E)
    stall = 1;
    burst(2'h1, 32'h6000, 24, 0);
    `CHK(drop_seen, 1'h1)
    stall = 0;
    wait_n(n + 16);
    repeat (40) @(negedge core_clk);
    n = tool.q.size();
    burst(2'h1, 32'h7000, 2, 3);
    wait_n(n + 2);
    `CHK(tool.q[n-1], 6'h08)
    `CHK(tool.q[n], 6'h0D)
    `CHK(tool.q[n+1], 6'h05)
    give_verdict;
  end
endmodule
